// file: design/drw_pkg.sv
// shared constants for the drive register pio window
package drw_pkg;
  localparam logic [7:0]  DRW_OFS_HIGH_BYTE   = 8'hDB;
  localparam logic [7:0]  DRW_OFS_LOW_BYTE    = 8'hDC;
  localparam logic [7:0]  DRW_OFS_CNT0        = 8'hE1;
  localparam logic [7:0]  DRW_OFS_CNT1        = 8'hE2;
  localparam logic [7:0]  DRW_OFS_CNT2        = 8'hE3;
  localparam logic [7:0]  DRW_OFS_CNT3        = 8'hE4;
  localparam logic [7:0]  DRW_RST_BYTE        = 8'h00;
  localparam logic [31:0] DRW_RST_COUNT       = 32'h0000_0000;
  // drive addresses in the processor's external data space
  localparam logic [15:0] DRW_XD_DATA         = 16'h31F0;
  localparam logic [12:0] DRW_XD_CMD_BLOCK    = 13'h063E;
  localparam logic [15:0] DRW_XD_ALT_STATUS   = 16'h33F6;
  localparam logic [2:0]  DRW_DA_ALT_STATUS   = 3'h6;
  localparam int          DRW_CLK_MHZ         = 25;
  localparam int          DRW_T_SETUP_NS      = 70;
  localparam int          DRW_T_ACTIVE_NS     = 165;
  localparam int          DRW_T_HOLD_NS       = 30;
  localparam int          DRW_SETUP_CYC  = (DRW_T_SETUP_NS * DRW_CLK_MHZ + 999) / 1000;
  localparam int          DRW_ACTIVE_CYC = (DRW_T_ACTIVE_NS * DRW_CLK_MHZ + 999) / 1000;
  localparam int          DRW_HOLD_CYC   = (DRW_T_HOLD_NS * DRW_CLK_MHZ + 999) / 1000;
  localparam int          DRW_TMR_W      = 4;
endpackage

// file: design/drw_pio_if.sv
// request and answer path between the window and the pio sequencer
`timescale 1ns/10ps
interface drw_pio_if;
  logic        start;
  logic        wr;
  logic        alt_sel;
  logic [2:0]  da;
  logic [15:0] wdata;
  logic        busy;
  logic        done;
  logic [15:0] rdata;
  modport ctrl (output start, output wr, output alt_sel, output da, output wdata,
                input busy, input done, input rdata);
  modport seq  (input start, input wr, input alt_sel, input da, input wdata,
                output busy, output done, output rdata);
endinterface

// file: design/drw_pio_seq.sv
// pio cycle sequencer driving the drive's parallel bus
`timescale 1ns/10ps
module drw_pio_seq
  import drw_pkg::*;
(
  input  wire logic  clock_i,
  input  wire logic  rst_b_i,
  drw_pio_if.seq     pio,
  input  wire logic [15:0] dd_i,
  input  wire logic        iordy_i,
  output logic [15:0]      dd_o,
  output logic             dd_oe_o,
  output logic [2:0]       da_o,
  output logic             cs0_b_o,
  output logic             cs1_b_o,
  output logic             dior_b_o,
  output logic             diow_b_o
);
  import drw_pkg::*;

  typedef enum logic [1:0] {
    DRW_S_IDLE   = 2'b00,
    DRW_S_SETUP  = 2'b01,
    DRW_S_ACTIVE = 2'b10,
    DRW_S_HOLD   = 2'b11
  } drw_state_t;

  localparam logic [DRW_TMR_W-1:0] SETUP_T  = DRW_TMR_W'(DRW_SETUP_CYC - 1);
  localparam logic [DRW_TMR_W-1:0] ACTIVE_T = DRW_TMR_W'(DRW_ACTIVE_CYC - 1);
  localparam logic [DRW_TMR_W-1:0] HOLD_T   = DRW_TMR_W'(DRW_HOLD_CYC - 1);

  drw_state_t           state_q, state_d;
  logic [DRW_TMR_W-1:0] tmr_q, tmr_d;
  logic                 wr_q, wr_d;
  logic [15:0]          dd_o_q, dd_o_d;
  logic [2:0]           da_q, da_d;
  logic                 cs0_b_q, cs0_b_d, cs1_b_q, cs1_b_d;
  logic                 dior_b_q, dior_b_d, diow_b_q, diow_b_d, oe_q, oe_d;
  logic                 done_q, done_d;
  logic [15:0]          rdata_q, rdata_d;
  logic [15:0]          dd_m_q, dd_s_q;
  logic                 rdy_m_q, rdy_s_q;

  always_comb begin
    state_d  = state_q;
    tmr_d    = tmr_q;
    wr_d     = wr_q;
    dd_o_d   = dd_o_q;
    da_d     = da_q;
    cs0_b_d  = cs0_b_q;
    cs1_b_d  = cs1_b_q;
    dior_b_d = dior_b_q;
    diow_b_d = diow_b_q;
    oe_d     = oe_q;
    done_d   = 1'b0;
    rdata_d  = rdata_q;
    case (state_q)
      DRW_S_IDLE: begin
        if (pio.start) begin
          state_d = DRW_S_SETUP;
          tmr_d   = SETUP_T;
          wr_d    = pio.wr;
          da_d    = pio.da;
          dd_o_d  = pio.wdata;
          oe_d    = pio.wr;
          cs0_b_d = pio.alt_sel;
          cs1_b_d = !pio.alt_sel;
        end
      end
      DRW_S_SETUP: begin
        if (tmr_q == '0) begin
          state_d  = DRW_S_ACTIVE;
          tmr_d    = ACTIVE_T;
          dior_b_d = wr_q;
          diow_b_d = !wr_q;
        end else begin
          tmr_d = tmr_q - 1'b1;
        end
      end
      DRW_S_ACTIVE: begin
        // the drive may stretch the strobe by pulling its ready line low
        if (tmr_q != '0) begin
          tmr_d = tmr_q - 1'b1;
        end else if (rdy_s_q) begin
          state_d  = DRW_S_HOLD;
          tmr_d    = HOLD_T;
          dior_b_d = 1'b1;
          diow_b_d = 1'b1;
          if (!wr_q) begin
            rdata_d = dd_s_q;
          end
        end
      end
      DRW_S_HOLD: begin
        if (tmr_q == '0) begin
          state_d = DRW_S_IDLE;
          cs0_b_d = 1'b1;
          cs1_b_d = 1'b1;
          oe_d    = 1'b0;
          done_d  = 1'b1;
        end else begin
          tmr_d = tmr_q - 1'b1;
        end
      end
      default: state_d = DRW_S_IDLE;
    endcase
  end

  always_ff @(posedge clock_i) begin
    dd_m_q  <= dd_i;
    dd_s_q  <= dd_m_q;
    rdy_m_q <= iordy_i;
    rdy_s_q <= rdy_m_q;
    if (!rst_b_i) begin
      state_q  <= DRW_S_IDLE;
      tmr_q    <= '0;
      wr_q     <= 1'b0;
      dd_o_q   <= 16'h0000;
      da_q     <= 3'h0;
      cs0_b_q  <= 1'b1;
      cs1_b_q  <= 1'b1;
      dior_b_q <= 1'b1;
      diow_b_q <= 1'b1;
      oe_q     <= 1'b0;
      done_q   <= 1'b0;
      rdata_q  <= 16'h0000;
    end else begin
      state_q  <= state_d;
      tmr_q    <= tmr_d;
      wr_q     <= wr_d;
      dd_o_q   <= dd_o_d;
      da_q     <= da_d;
      cs0_b_q  <= cs0_b_d;
      cs1_b_q  <= cs1_b_d;
      dior_b_q <= dior_b_d;
      diow_b_q <= diow_b_d;
      oe_q     <= oe_d;
      done_q   <= done_d;
      rdata_q  <= rdata_d;
    end
  end

  assign pio.busy  = (state_q != DRW_S_IDLE);
  assign pio.done  = done_q;
  assign pio.rdata = rdata_q;
  assign dd_o      = dd_o_q;
  assign dd_oe_o   = oe_q;
  assign da_o      = da_q;
  assign cs0_b_o   = cs0_b_q;
  assign cs1_b_o   = cs1_b_q;
  assign dior_b_o  = dior_b_q;
  assign diow_b_o  = diow_b_q;
endmodule

// file: design/drive_register_pio_window.sv
// staging registers and transfer counter for processor pio access to the drive
`timescale 1ns/10ps
module drive_register_pio_window (
  input  wire logic         clock_i,
  input  wire logic         rst_b_i,
  // processor special-function register bus
  input  wire logic [7:0]   sfr_addr_i,
  input  wire logic         sfr_wr_i,
  input  wire logic         sfr_rd_i,
  input  wire logic [7:0]   sfr_wdata_i,
  output logic [7:0]        sfr_rdata_o,
  // processor external data cycles aimed at the drive's registers
  input  wire logic [15:0]  xd_addr_i,
  input  wire logic         xd_wr_i,
  input  wire logic         xd_rd_i,
  input  wire logic [7:0]   xd_wdata_i,
  output logic [7:0]        xd_rdata_o,
  output logic              pio_done_flag_o,
  // transfer progress from the data mover
  input  wire logic         xfer_beat_i,
  input  wire logic [1:0]   xfer_beat_bytes_i,
  input  wire logic         xfer_end_i,
  output logic              xfer_active_o,
  output logic              drive_transfer_error_o,
  // drive parallel bus
  input  wire logic [15:0]  dd_i,
  input  wire logic         iordy_i,
  output logic [15:0]       dd_o,
  output logic              dd_oe_o,
  output logic [2:0]        da_o,
  output logic              cs0_b_o,
  output logic              cs1_b_o,
  output logic              dior_b_o,
  output logic              diow_b_o
);
  import drw_pkg::*;

  drw_pio_if pio ();

  logic [7:0]  high_q;
  logic [7:0]  high_d;
  logic [7:0]  low_q;
  logic [7:0]  low_d;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic        active_q;
  logic        active_d;
  logic        err_q;
  logic        err_d;
  logic        done_flag_q;
  logic        done_flag_d;
  logic        is16_q;
  logic        is16_d;
  logic        rd_acc_q;
  logic        rd_acc_d;
  logic [7:0]  sfr_rdata_q;
  logic [7:0]  sfr_rdata_d;
  logic        xd_cmd_hit;
  logic        xd_alt_hit;
  logic        xd_hit;
  logic        start;
  logic [31:0] beat_bytes;

  assign xd_cmd_hit = (xd_addr_i[15:3] == DRW_XD_CMD_BLOCK);
  assign xd_alt_hit = (xd_addr_i == DRW_XD_ALT_STATUS);
  assign xd_hit     = xd_cmd_hit || xd_alt_hit;
  // an access arriving while the sequencer is busy is dropped; firmware waits for done
  assign start      = xd_hit && (xd_wr_i || xd_rd_i) && !pio.busy;
  assign beat_bytes = {30'h0000_0000, xfer_beat_bytes_i};

  assign pio.start   = start;
  assign pio.wr      = xd_wr_i;
  assign pio.alt_sel = xd_alt_hit;
  assign pio.da      = xd_alt_hit ? DRW_DA_ALT_STATUS : xd_addr_i[2:0];
  assign pio.wdata   = {high_q, xd_wdata_i};

  // kind of the running access and its completion flag
  always_comb begin
    is16_d      = is16_q;
    rd_acc_d    = rd_acc_q;
    done_flag_d = done_flag_q;
    if (start) begin
      done_flag_d = 1'b0;
      is16_d      = (xd_addr_i == DRW_XD_DATA);
      rd_acc_d    = !xd_wr_i;
    end
    // a completion landing on the cycle of a new start still sets the flag
    if (pio.done) begin
      done_flag_d = 1'b1;
    end
  end

  always_comb begin
    high_d = high_q;
    low_d  = low_q;
    if (sfr_wr_i && sfr_addr_i == DRW_OFS_HIGH_BYTE) begin
      high_d = sfr_wdata_i;
    end
    if (sfr_wr_i && sfr_addr_i == DRW_OFS_LOW_BYTE) begin
      low_d = sfr_wdata_i;
    end
    // bytes change only at completion, so they hold until the next access;
    // the processor strobe is long gone by then, hence the stored access kind
    if (pio.done && rd_acc_q) begin
      low_d = pio.rdata[7:0];
      if (is16_q) begin
        high_d = pio.rdata[15:8];
      end
    end
  end

  always_comb begin
    cnt_d    = cnt_q;
    active_d = active_q;
    err_d    = err_q;
    if (active_q && xfer_beat_i) begin
      // a beat that uses up the count closes the transfer cleanly
      if (cnt_q <= beat_bytes) begin
        cnt_d    = 32'h0000_0000;
        active_d = 1'b0;
      end else begin
        cnt_d = cnt_q - beat_bytes;
      end
    end
    // upper bytes load the live counter, even while a transfer runs
    if (sfr_wr_i) begin
      case (sfr_addr_i)
        DRW_OFS_CNT1: cnt_d[15:8]  = sfr_wdata_i;
        DRW_OFS_CNT2: cnt_d[23:16] = sfr_wdata_i;
        DRW_OFS_CNT3: cnt_d[31:24] = sfr_wdata_i;
        DRW_OFS_CNT0: begin
          cnt_d[7:0] = sfr_wdata_i;
          active_d   = 1'b1;
          err_d      = 1'b0;
        end
        default: cnt_d = cnt_d;
      endcase
    end
    // an end seen in the arming cycle counts only if a transfer was already active, and then the set wins over the clear
    if (active_q && xfer_end_i && !(xfer_beat_i && cnt_q <= beat_bytes)) begin
      err_d    = 1'b1;
      active_d = 1'b0;
    end
  end

  // reads are registered, so data follows the strobe by one cycle
  always_comb begin
    sfr_rdata_d = sfr_rdata_q;
    if (sfr_rd_i) begin
      case (sfr_addr_i)
        DRW_OFS_HIGH_BYTE: sfr_rdata_d = high_q;
        DRW_OFS_LOW_BYTE:  sfr_rdata_d = low_q;
        DRW_OFS_CNT0:      sfr_rdata_d = cnt_q[7:0];
        DRW_OFS_CNT1:      sfr_rdata_d = cnt_q[15:8];
        DRW_OFS_CNT2:      sfr_rdata_d = cnt_q[23:16];
        DRW_OFS_CNT3:      sfr_rdata_d = cnt_q[31:24];
        default:           sfr_rdata_d = DRW_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      high_q      <= DRW_RST_BYTE;
      low_q       <= DRW_RST_BYTE;
      is16_q      <= 1'b0;
      rd_acc_q    <= 1'b0;
      done_flag_q <= 1'b0;
      cnt_q       <= DRW_RST_COUNT;
      active_q    <= 1'b0;
      err_q       <= 1'b0;
      sfr_rdata_q <= DRW_RST_BYTE;
    end else begin
      high_q      <= high_d;
      low_q       <= low_d;
      is16_q      <= is16_d;
      rd_acc_q    <= rd_acc_d;
      done_flag_q <= done_flag_d;
      cnt_q       <= cnt_d;
      active_q    <= active_d;
      err_q       <= err_d;
      sfr_rdata_q <= sfr_rdata_d;
    end
  end

  // the direct read of a drive address returns a dummy zero, results come via staging
  always_ff @(posedge clock_i) begin
    xd_rdata_o <= DRW_RST_BYTE;
  end

  assign sfr_rdata_o            = sfr_rdata_q;
  assign pio_done_flag_o        = done_flag_q;
  assign xfer_active_o          = active_q;
  assign drive_transfer_error_o = err_q;

  // the sequencer owns all drive pin timing; this module only stages bytes and keeps the transfer counter
  drw_pio_seq u_seq (
    .clock_i  (clock_i),
    .rst_b_i  (rst_b_i),
    .pio      (pio),
    .dd_i     (dd_i),
    .iordy_i  (iordy_i),
    .dd_o     (dd_o),
    .dd_oe_o  (dd_oe_o),
    .da_o     (da_o),
    .cs0_b_o  (cs0_b_o),
    .cs1_b_o  (cs1_b_o),
    .dior_b_o (dior_b_o),
    .diow_b_o (diow_b_o)
  );
endmodule

// file: tb/drw_drive_model.sv
// behavioural drive on the parallel bus, prompt or slow to signal ready
`timescale 1ns/10ps
module drw_drive_model (
  input  wire logic        clock_i,
  input  wire logic [15:0] dd_o,
  input  wire logic        dd_oe_o,
  input  wire logic [2:0]  da_o,
  input  wire logic        cs0_b_o,
  input  wire logic        cs1_b_o,
  input  wire logic        dior_b_o,
  input  wire logic        diow_b_o,
  input  wire logic        slow_i,
  output logic [15:0]      dd_i,
  output logic             iordy_i
);
  logic [15:0] mem[16];
  logic [15:0] last = 16'h0000;
  logic [3:0]  low_n = 4'h0;
  wire  [3:0]  idx = {cs0_b_o, da_o};
  wire         sel = !(cs0_b_o && cs1_b_o);
  initial for (int i = 0; i < 16; i++) mem[i] = 16'h1357 * (i + 1);
  // a released bus shows the inverted last word, so a stale capture cannot pass
  assign dd_i = (sel && !dior_b_o) ? mem[idx] : ~last;
  assign iordy_i = !slow_i || low_n > 4'h9;
  always @(posedge clock_i) begin
    if (sel && !dior_b_o) last <= mem[idx];
    if (sel && !diow_b_o && dd_oe_o) mem[idx] <= dd_o;
    low_n <= (dior_b_o && diow_b_o) ? 4'h0 : low_n + 4'(low_n != 4'hF);
  end
endmodule

// file: tb/drw_chk_sva.sv
// concurrent checks on the window's top-level ports
`timescale 1ns/10ps
module drw_chk (
  input wire logic        clock_i,
  input wire logic        rst_b_i,
  input wire logic [7:0]  sfr_addr_i,
  input wire logic        sfr_wr_i,
  input wire logic [7:0]  sfr_wdata_i,
  input wire logic [15:0] xd_addr_i,
  input wire logic        xd_wr_i,
  input wire logic        xd_rd_i,
  input wire logic [7:0]  xd_rdata_o,
  input wire logic        pio_done_flag_o,
  input wire logic        xfer_beat_i,
  input wire logic        xfer_end_i,
  input wire logic        xfer_active_o,
  input wire logic        drive_transfer_error_o,
  input wire logic        dd_oe_o,
  input wire logic        cs0_b_o,
  input wire logic        cs1_b_o,
  input wire logic        dior_b_o,
  input wire logic        diow_b_o
);
  import drw_pkg::*;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  wire arm = sfr_wr_i && sfr_addr_i == DRW_OFS_CNT0;
  // a zero low byte still arms the counter, but only nonzero loads are judged
  property p_arm;
    arm && sfr_wdata_i != 8'h00 && !xfer_end_i && !xfer_beat_i
      |=> xfer_active_o && !drive_transfer_error_o;
  endproperty
  a_arm: assert property (p_arm) else $error("no arm");
  property p_end;
    xfer_end_i && xfer_active_o && !xfer_beat_i && !sfr_wr_i
      |=> drive_transfer_error_o && !xfer_active_o;
  endproperty
  a_end: assert property (p_end) else $error("no error");
  property p_sticky; drive_transfer_error_o && !arm |=> drive_transfer_error_o; endproperty
  a_sticky: assert property (p_sticky) else $error("error lost");
  property p_hold;
    pio_done_flag_o && !xd_rd_i && !xd_wr_i && !$past(xd_rd_i) && !$past(xd_wr_i)
      |=> pio_done_flag_o;
  endproperty
  a_hold: assert property (p_hold) else $error("done dropped");
  property p_rdgo;
    pio_done_flag_o && xd_rd_i && xd_addr_i == DRW_XD_DATA |-> ##[2:5] !dior_b_o;
  endproperty
  a_rdgo: assert property (p_rdgo) else $error("no read");
  property p_wr; !diow_b_o |-> dd_oe_o && dior_b_o && !(cs0_b_o && cs1_b_o); endproperty
  a_wr: assert property (p_wr) else $error("bad write");
  property p_rd; !dior_b_o |-> !dd_oe_o && (cs0_b_o != cs1_b_o); endproperty
  a_rd: assert property (p_rd) else $error("bad read");
  property p_dummy; xd_rd_i |=> xd_rdata_o == 8'h00; endproperty
  a_dummy: assert property (p_dummy) else $error("dummy data");
  c_err: cover property (drive_transfer_error_o);
  c_slow: cover property (!dior_b_o [*8]);
  c_alt: cover property (!diow_b_o && !cs1_b_o);
endmodule

// file: tb/drive_register_pio_window_tb_top.sv
// self-checking bench for the drive register pio window
`timescale 1ns/10ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_mismatch++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module drive_register_pio_window_tb_top;
  import drw_pkg::*;
  logic        clock_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        rd_d = 1'b0;
  logic        sfr_wr_i, sfr_rd_i, xd_wr_i, xd_rd_i, xfer_beat_i, xfer_end_i, slow_i;
  logic        pio_done_flag_o, xfer_active_o, drive_transfer_error_o, dd_oe_o, iordy_i;
  logic        cs0_b_o, cs1_b_o, dior_b_o, diow_b_o;
  logic [1:0]  xfer_beat_bytes_i;
  logic [2:0]  da_o;
  logic [7:0]  sfr_addr_i, sfr_wdata_i, sfr_rdata_o, xd_wdata_i, xd_rdata_o, hb, b, e;
  logic [15:0] xd_addr_i, dd_i, dd_o, a, rem;
  logic [15:0] w[16];
  logic [7:0]  q[$];
  int          n_mismatch = 0;
  int          compares = 0;
  int          cnt, k;
  drive_register_pio_window DUT (.*);
  drw_drive_model u_drv (.*);
  always #20 clock_i = ~clock_i;
  task automatic sw(input logic [7:0] ad, input logic [7:0] d);
    @(negedge clock_i);
    sfr_addr_i = ad;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(negedge clock_i);
    sfr_wr_i = 1'b0;
  endtask
  task automatic sr(input logic [7:0] ad, input logic [7:0] ex);
    @(negedge clock_i);
    sfr_addr_i = ad;
    sfr_rd_i = 1'b1;
    q.push_back(ex);
    @(negedge clock_i);
    sfr_rd_i = 1'b0;
  endtask
  task automatic xa(input logic [15:0] ad, input logic wr, input logic [7:0] d);
    @(negedge clock_i);
    xd_addr_i = ad;
    xd_wdata_i = d;
    xd_wr_i = wr;
    xd_rd_i = !wr;
    @(negedge clock_i);
    {xd_wr_i, xd_rd_i} = 2'b00;
    cnt = 0;
    repeat (2) @(negedge clock_i);
    while (pio_done_flag_o !== 1'b1 && cnt < 40) begin
      @(negedge clock_i);
      cnt++;
    end
    if (cnt == 40) n_mismatch++;
  endtask
  task automatic pl(input logic en, input logic [1:0] n);
    @(negedge clock_i);
    xfer_end_i = en;
    xfer_beat_i = !en;
    xfer_beat_bytes_i = n;
    @(negedge clock_i);
    {xfer_end_i, xfer_beat_i} = 2'b00;
  endtask
  task automatic end_of_test;
    if (n_mismatch == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clock_i) begin
    if (rd_d) begin
      e = q.pop_front();
      `CHK(sfr_rdata_o, e)
    end
    rd_d <= sfr_rd_i;
  end
  initial begin
    {sfr_wr_i, sfr_rd_i, xd_wr_i, xd_rd_i, xfer_beat_i, xfer_end_i, slow_i} = '0;
    {sfr_addr_i, sfr_wdata_i, xd_addr_i, xd_wdata_i, xfer_beat_bytes_i, hb} = '0;
    void'($urandom(60));
    for (int i = 0; i < 16; i++) w[i] = 16'h1357 * (i + 1);
    repeat (5) @(negedge clock_i);
    rst_b_i = 1'b1;
    sr(DRW_OFS_HIGH_BYTE, 8'h00);
    sr(DRW_OFS_LOW_BYTE, 8'h00);
    sr(DRW_OFS_CNT0, 8'h00);
    sr(8'hDA, 8'h00);
    // every drive register, alternating prompt and slow drive
    for (int i = 0; i < 9; i++) begin
      a = (i == 8) ? DRW_XD_ALT_STATUS : DRW_XD_DATA + 16'(i);
      k = (i == 8) ? 14 : i;
      slow_i = i[0];
      b = 8'($urandom);
      if (i > 0) begin
        xa(a, 1'b1, b);
        w[k] = {hb, b};
        `CHK(u_drv.mem[k][7:0], b)
      end
      xa(a, 1'b0, 8'h00);
      if (i == 0) hb = w[0][15:8];
      sr(DRW_OFS_LOW_BYTE, w[k][7:0]);
      sr(DRW_OFS_HIGH_BYTE, hb);
    end
    hb = 8'($urandom);
    sw(DRW_OFS_HIGH_BYTE, hb);
    b = 8'($urandom);
    // preload the low staging byte so a write that disturbs it shows up
    sw(DRW_OFS_LOW_BYTE, ~b);
    xa(DRW_XD_DATA, 1'b1, b);
    `CHK(u_drv.mem[0], {hb, b})
    sr(DRW_OFS_LOW_BYTE, ~b);
    sr(DRW_OFS_HIGH_BYTE, hb);
    xa(DRW_XD_DATA, 1'b0, 8'h00);
    sr(DRW_OFS_LOW_BYTE, b);
    repeat (20) @(negedge clock_i);
    sr(DRW_OFS_HIGH_BYTE, hb);
    sw(DRW_OFS_CNT1, 8'h01);
    sw(DRW_OFS_CNT0, 8'h05);
    `CHK(xfer_active_o, 1'b1)
    rem = 16'h0105;
    repeat (4) begin
      b = 8'($urandom_range(3, 1));
      pl(1'b0, b[1:0]);
      rem = rem - 16'(b);
    end
    sr(DRW_OFS_CNT0, rem[7:0]);
    sr(DRW_OFS_CNT1, rem[15:8]);
    pl(1'b1, 2'h0);
    `CHK({xfer_active_o, drive_transfer_error_o}, 2'b01)
    sw(DRW_OFS_CNT1, 8'h00);
    sw(DRW_OFS_CNT0, 8'h03);
    `CHK({xfer_active_o, drive_transfer_error_o}, 2'b10)
    pl(1'b0, 2'h3);
    pl(1'b1, 2'h0);
    `CHK({xfer_active_o, drive_transfer_error_o}, 2'b00)
    sr(DRW_OFS_CNT0, 8'h00);
    repeat (2) @(negedge clock_i);
    end_of_test();
  end
  // roughly thirteen times the expected run length
  initial begin
    #200000;
    n_mismatch++;
    end_of_test();
  end
endmodule
bind drive_register_pio_window drw_chk u_chk (.*);
